/* common/fault_pkg.sv */
// Package for the supply fault-reaction block: timing, positions, APB map.
// Assumes a 125 MHz system clock and a 32-bit APB register port.
package fault_pkg;

  // Clock rate and deglitch windows
  localparam int CLK_MHZ         = 125;
  localparam int SHORT_MIN_US    = 15;   // Supplies, references, pumps
  localparam int SHORT_MAX_US    = 30;
  localparam int LONG_MIN_US     = 10;   // Regulator rails
  localparam int LONG_MAX_US     = 40;
  // Filter length sits inside the window: least time rounded up
  localparam int SHORT_CYCLES    = SHORT_MIN_US * CLK_MHZ;
  localparam int LONG_CYCLES     = LONG_MIN_US * CLK_MHZ;
  localparam int NUM_FAULTS      = 14;

  // Fault indices; diag_mux group one position is index + 2
  localparam int F_AVDD_UV       = 0;
  localparam int F_REF_HIGH      = 1;
  localparam int F_REF_LOW       = 2;
  localparam int F_PUMP_LOW_UV   = 3;
  localparam int F_PUMP_LOW_OV   = 4;
  localparam int F_PUMP_HIGH_OV  = 5;
  localparam int F_PREREG_UV     = 6;
  localparam int F_PREREG_OV     = 7;
  localparam int F_XCVR_UV       = 8;
  localparam int F_XCVR_OV       = 9;
  localparam int F_IO_UV         = 10;
  localparam int F_IO_OV         = 11;
  localparam int F_CORE_UV       = 12;
  localparam int F_CORE_OV       = 13;
  localparam int DIAG_BASE       = 2;

  // Status register two bit positions
  localparam int ST2_CORE_UV     = 0;
  localparam int ST2_CORE_OV     = 1;
  localparam int ST2_IO_UV       = 2;
  localparam int ST2_IO_OV       = 3;
  localparam int ST2_XCVR_UV     = 4;
  localparam int ST2_XCVR_OV     = 5;
  localparam int ST2_PREREG_UV   = 6;
  localparam int ST2_PREREG_OV   = 7;

  // Register byte addresses
  localparam logic [11:0] ADDR_STATUS2  = 12'h000;
  localparam logic [11:0] ADDR_CONFIG   = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h00c;
  localparam logic [11:0] ADDR_LIVE     = 12'h010;
  localparam logic [11:0] ADDR_STATE    = 12'h014;

  // Config fields
  localparam int CFG_CORE_UNMASK = 0;
  localparam int CFG_IO_5V       = 1;
  localparam int CFG_DIAG_LSB    = 4;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  // Device state
  typedef enum logic [1:0] {
    ST_ACTIVE  = 2'b00,
    ST_RESET   = 2'b01,
    ST_STANDBY = 2'b10
  } dev_state_t;

  // Raw comparator inputs, asynchronous; synchronised and deglitched inside the block
  typedef struct packed {
    logic analog_supply_uv_ok;
    logic reference_high_error;
    logic reference_low_error;
    logic pump_low_uv_ok;
    logic pump_low_overvolt;
    logic pump_high_overvolt;
    logic prereg_uv_ok;
    logic prereg_overvolt;
    logic transceiver_rail_uv_ok;
    logic transceiver_rail_overvolt;
    logic io_rail_uv_ok_3v3;
    logic io_rail_uv_ok_5v;
    logic io_rail_overvolt_3v3;
    logic io_rail_overvolt_5v;
    logic core_rail_uv_ok;
    logic core_rail_overvolt;
  } comp_in_t;

  // Idle comparator levels: every *_uv_ok high, every error input low
  localparam comp_in_t COMP_IDLE = comp_in_t'(16'h92b2);

  // APB request
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage

/* design/deglitch_filter.sv */
// One deglitch filter: a condition must hold for LEN cycles to set the flag.
// Assumes the condition is already synchronous to clk_sys.
`timescale 1ns/1ps
module deglitch_filter
  import fault_pkg::*;
#(
  parameter int LEN = 1875
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Condition and result
  input  wire logic cond,
  output logic      flag
);

  localparam int CW = $clog2(LEN + 1);

  logic [CW-1:0] count;

  // Refuse a length that the counter cannot time
  if (LEN < 1) begin : g_bad_len
    $error("deglitch_filter: LEN must be at least 1");
  end

  // Count while present; restart as soon as the condition drops
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
      flag  <= 1'b0;
    end else if (!cond) begin
      count <= '0;
      flag  <= 1'b0;
    end else if (count == CW'(LEN - 1)) begin
      flag <= 1'b1;
    end else begin
      count <= count + CW'(1);
    end
  end

endmodule

/* design/supply_fault_reaction.sv */
// Fault reaction for the supply monitors: deglitch, react, report over APB.
// Assumes comparator outputs arrive asynchronously and a 125 MHz clk_sys.
//
// Summary of operation
// - Analog supply undervoltage: reset, drive off, standby
// - Reference high error: reset, drive off, standby
// - Reference low error: reset, drive off, standby
// - Low pump overvoltage: reset, drive off, standby
// - High pump overvoltage: reset, drive off, standby
// - Preregulator faults only set their flag
// - Transceiver undervoltage only sets its flag
// - Transceiver or I/O overvoltage disables drive
// - I/O undervoltage: reset, drive off, reset state
// - I/O comparators chosen by voltage setting
// - Core faults act only when unmasked
// - Each error shown on diag mux
// - Preregulator faults in status bits 6, 7
// - Core faults in status bits 0, 1
`timescale 1ns/1ps
module supply_fault_reaction
  import fault_pkg::*;
#(
  parameter int SHORT_LEN = SHORT_CYCLES,
  parameter int LONG_LEN  = LONG_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // Raw comparator outputs
  input  wire comp_in_t    compIn,
  // APB slave
  input  wire apb_req_t    apbReq,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Outputs toward the microcontroller
  output logic             mcu_reset_out_n,
  output logic             safing_drive_enable,
  output logic             diag_mux,
  output logic             irq
);

  // Refuse filter lengths that the counters cannot time
  if (SHORT_LEN < 1 || LONG_LEN < 1) begin : g_bad_len
    $error("supply_fault_reaction: filter lengths must be positive");
  end

  // Two-flop synchronisers; stage one feeds only stage two
  comp_in_t syncA;
  comp_in_t syncB;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      // Idle levels, so no filter starts counting a false fault
      syncA <= COMP_IDLE;
      syncB <= COMP_IDLE;
    end else begin
      syncA <= compIn;
      syncB <= syncA;
    end
  end

  // Configuration held in the config register
  logic [31:0] config_r;
  logic        coreUnmask;
  logic        io5v;
  logic [3:0]  diagSel;

  assign coreUnmask = config_r[CFG_CORE_UNMASK];
  assign io5v       = config_r[CFG_IO_5V];
  assign diagSel    = config_r[CFG_DIAG_LSB +: 4];

  // Raw fault conditions, active high
  logic [NUM_FAULTS-1:0] cond;

  always_comb begin
    cond = '0;
    cond[F_AVDD_UV]      = ~syncB.analog_supply_uv_ok;
    cond[F_REF_HIGH]     = syncB.reference_high_error;
    cond[F_REF_LOW]      = syncB.reference_low_error;
    cond[F_PUMP_LOW_UV]  = ~syncB.pump_low_uv_ok;
    cond[F_PUMP_LOW_OV]  = syncB.pump_low_overvolt;
    cond[F_PUMP_HIGH_OV] = syncB.pump_high_overvolt;
    cond[F_PREREG_UV]    = ~syncB.prereg_uv_ok;
    cond[F_PREREG_OV]    = syncB.prereg_overvolt;
    cond[F_XCVR_UV]      = ~syncB.transceiver_rail_uv_ok;
    cond[F_XCVR_OV]      = syncB.transceiver_rail_overvolt;
    // Pick the comparator pair for the selected I/O voltage
    cond[F_IO_UV] = io5v ? ~syncB.io_rail_uv_ok_5v
                         : ~syncB.io_rail_uv_ok_3v3;
    cond[F_IO_OV] = io5v ? syncB.io_rail_overvolt_5v
                         : syncB.io_rail_overvolt_3v3;
    cond[F_CORE_UV]      = ~syncB.core_rail_uv_ok;
    cond[F_CORE_OV]      = syncB.core_rail_overvolt;
  end

  // One filter per fault; the first six use the short window
  logic [NUM_FAULTS-1:0] flag;

  generate
    for (genvar i = 0; i < NUM_FAULTS; i++) begin : g_filt
      deglitch_filter #(
        .LEN (i <= F_PUMP_HIGH_OV ? SHORT_LEN : LONG_LEN)
      ) u_filt (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .cond    (cond[i]),
        .flag    (flag[i])
      );
    end
  endgenerate

  // Reaction classes
  logic toStandby;
  logic toReset;
  logic driveOff;

  always_comb begin
    toStandby = flag[F_AVDD_UV]
              | flag[F_REF_HIGH]
              | flag[F_REF_LOW]
              | flag[F_PUMP_LOW_OV]
              | flag[F_PUMP_HIGH_OV];
    // Preregulator, transceiver undervoltage and low pump undervoltage
    // only flag; they never reach these terms
    toReset = flag[F_IO_UV]
            | (coreUnmask & flag[F_CORE_UV]);
    driveOff = toStandby | toReset
             | flag[F_XCVR_OV] | flag[F_IO_OV]
             | (coreUnmask & flag[F_CORE_OV]);
  end

  // Device state: standby outranks reset; leaves once faults clear
  dev_state_t devState;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      devState <= ST_ACTIVE;
    end else begin
      case (devState)
        ST_ACTIVE: begin
          if (toStandby)    devState <= ST_STANDBY;
          else if (toReset) devState <= ST_RESET;
        end
        ST_RESET: begin
          if (toStandby)     devState <= ST_STANDBY;
          else if (!toReset) devState <= ST_ACTIVE;
        end
        ST_STANDBY: begin
          if (!toStandby && !toReset) devState <= ST_ACTIVE;
        end
        default: devState <= ST_ACTIVE;
      endcase
    end
  end

  // Pin outputs, registered; low during reset for safety
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mcu_reset_out_n     <= 1'b0;
      safing_drive_enable <= 1'b0;
    end else begin
      mcu_reset_out_n     <= ~(toStandby | toReset);
      safing_drive_enable <= ~driveOff;
    end
  end

  // Diagnostic mux group one: positions 2..15 carry the flags
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      diag_mux <= 1'b0;
    end else if (diagSel >= 4'(DIAG_BASE)) begin
      diag_mux <= flag[diagSel - 4'(DIAG_BASE)];
    end else begin
      diag_mux <= 1'b0;
    end
  end

  // Status register two, live flag view
  logic [7:0] status2;

  always_comb begin
    status2 = '0;
    status2[ST2_CORE_UV]   = flag[F_CORE_UV];
    status2[ST2_CORE_OV]   = flag[F_CORE_OV];
    status2[ST2_IO_UV]     = flag[F_IO_UV];
    status2[ST2_IO_OV]     = flag[F_IO_OV];
    status2[ST2_XCVR_UV]   = flag[F_XCVR_UV];
    status2[ST2_XCVR_OV]   = flag[F_XCVR_OV];
    status2[ST2_PREREG_UV] = flag[F_PREREG_UV];
    status2[ST2_PREREG_OV] = flag[F_PREREG_OV];
  end

  // Interrupt status: sticky on flag rise, write one to clear
  logic [NUM_FAULTS-1:0] flagDly;
  logic [NUM_FAULTS-1:0] irqStat;
  logic [NUM_FAULTS-1:0] irqMask;
  logic                  wrStrobe;
  logic                  rdStrobe;

  // A write lands only at the access edge that sees pready high
  assign wrStrobe = apbReq.psel & apbReq.penable & apbReq.pwrite & pready;
  assign rdStrobe = apbReq.psel & ~apbReq.penable & ~apbReq.pwrite;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flagDly <= '0;
      irqStat <= '0;
    end else begin
      flagDly <= flag;
      // Set wins over a clear in the same cycle
      if (wrStrobe && apbReq.paddr == ADDR_IRQ_STAT) begin
        irqStat <= (irqStat & ~apbReq.pwdata[NUM_FAULTS-1:0])
                 | (flag & ~flagDly);
      end else begin
        irqStat <= irqStat | (flag & ~flagDly);
      end
    end
  end

  // Writable registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      config_r <= CFG_RESET;
      irqMask  <= '0;
    end else if (wrStrobe) begin
      case (apbReq.paddr)
        ADDR_CONFIG:   config_r <= apbReq.pwdata & 32'h0000_00f3;
        ADDR_IRQ_MASK: irqMask  <= apbReq.pwdata[NUM_FAULTS-1:0];
        default:       ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat & irqMask);
    end
  end

  // APB read data captured in setup; no wait state, answer in first access cycle
  logic        addrOk;

  always_comb begin
    case (apbReq.paddr)
      ADDR_STATUS2, ADDR_CONFIG, ADDR_IRQ_STAT,
      ADDR_IRQ_MASK, ADDR_LIVE, ADDR_STATE: addrOk = 1'b1;
      default:                              addrOk = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= '0;
    end else if (rdStrobe) begin
      case (apbReq.paddr)
        ADDR_STATUS2:  prdata <= {24'h00_0000, status2};
        ADDR_CONFIG:   prdata <= config_r;
        ADDR_IRQ_STAT: prdata <= {18'h0_0000, irqStat};
        ADDR_IRQ_MASK: prdata <= {18'h0_0000, irqMask};
        ADDR_LIVE:     prdata <= {18'h0_0000, flag};
        ADDR_STATE:    prdata <= {30'h0000_0000, devState};
        default:       prdata <= '0;
      endcase
    end
  end

  // Ready and error stand one cycle; pslverr for unmapped addresses
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= apbReq.psel & ~apbReq.penable;
      pslverr <= apbReq.psel & ~apbReq.penable & ~addrOk;
    end
  end

endmodule

/* dv/mcu_model.sv */
// Microcontroller model: counts the reset pulses it receives.
// Assumes the reset line is a registered output of the fault block.
`timescale 1ns/1ps
module mcu_model (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Line from the fault block
  input  wire logic mcu_reset_out_n,
  // Observed count
  output int        resetCount
);
  logic wasRun;
  // Count falls only after release; device reset holds the line low
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wasRun     <= 1'b0;
      resetCount <= 0;
    end else begin
      wasRun <= mcu_reset_out_n;
      if (wasRun && !mcu_reset_out_n) resetCount <= resetCount + 1;
    end
  end
endmodule

/* dv/supply_fault_reaction_assertions.sv */
// Checker for supply_fault_reaction: fault reactions and diag output.
// Assumes short filter lengths, so 8 held cycles cover sync and filter.
`timescale 1ns/1ps
module supply_fault_reaction_assertions
  import fault_pkg::*;
#(
  parameter int SHORT_LEN = 4,
  parameter int LONG_LEN  = 3
) (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_b,
  // Watched ports
  input wire comp_in_t    compIn,
  input wire apb_req_t    apbReq,
  input wire logic        pready,
  input wire logic        mcu_reset_out_n,
  input wire logic        safing_drive_enable,
  input wire logic        diag_mux
);
  logic [31:0] cfg;
  logic        ioUv, ioOv, coreUv, coreOv, halt, quiet;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Eight held cycles cover two sync flops, the filter and the output
  if (SHORT_LEN > 5 || LONG_LEN > 5) begin : g_len_check
    $error("checker needs filter lengths of at most 5");
  end
  // Mirror of config, written at the access edge like the design
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) cfg <= CFG_RESET;
    else if (apbReq.psel && apbReq.penable && apbReq.pwrite && pready &&
             apbReq.paddr == ADDR_CONFIG) cfg <= apbReq.pwdata;
  end
  // Selected comparators; unselected set never reacts
  assign ioUv = cfg[CFG_IO_5V] ? !compIn.io_rail_uv_ok_5v
                               : !compIn.io_rail_uv_ok_3v3;
  assign ioOv = cfg[CFG_IO_5V] ? compIn.io_rail_overvolt_5v
                               : compIn.io_rail_overvolt_3v3;
  assign coreUv = cfg[CFG_CORE_UNMASK] && !compIn.core_rail_uv_ok;
  assign coreOv = cfg[CFG_CORE_UNMASK] && compIn.core_rail_overvolt;
  assign halt = !compIn.analog_supply_uv_ok || compIn.reference_high_error ||
                compIn.reference_low_error || compIn.pump_low_overvolt ||
                compIn.pump_high_overvolt;
  assign quiet = !(halt || ioUv || ioOv || coreUv || coreOv ||
                   compIn.transceiver_rail_overvolt);
  sequence held(c);
    c [*8];
  endsequence
  property both_low(c);
    held(c) |=> !mcu_reset_out_n && !safing_drive_enable;
  endproperty
  property drive_low(c);
    held(c) |=> !safing_drive_enable;
  endproperty
  avdd_react_a: assert property (both_low(!compIn.analog_supply_uv_ok)) else $error("avdd fault kept outputs high");
  refh_react_a: assert property (both_low(compIn.reference_high_error)) else $error("ref high fault ignored");
  refl_react_a: assert property (both_low(compIn.reference_low_error)) else $error("ref low fault ignored");
  pumpl_react_a: assert property (both_low(compIn.pump_low_overvolt)) else $error("low pump fault ignored");
  pumph_react_a: assert property (both_low(compIn.pump_high_overvolt)) else $error("high pump fault ignored");
  io_uv_react_a: assert property (both_low(ioUv)) else $error("io undervoltage ignored");
  core_uv_react_a: assert property (both_low(coreUv)) else $error("core undervoltage ignored");
  xcvr_ov_drive_a: assert property (drive_low(compIn.transceiver_rail_overvolt)) else $error("xcvr overvoltage ignored");
  io_ov_drive_a: assert property (drive_low(ioOv)) else $error("io overvoltage ignored");
  quiet_run_a: assert property (held(quiet) |=> mcu_reset_out_n && safing_drive_enable) else $error("outputs low without reacting fault");
  diag_pos_a: assert property ((cfg[7:4] == 4'h2 && !compIn.analog_supply_uv_ok) [*8] |=> diag_mux) else $error("diag misses avdd flag");
endmodule

bind supply_fault_reaction supply_fault_reaction_assertions #(
  .SHORT_LEN(SHORT_LEN),
  .LONG_LEN (LONG_LEN)
) chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .compIn(compIn), .apbReq(apbReq),
  .pready(pready), .mcu_reset_out_n(mcu_reset_out_n),
  .safing_drive_enable(safing_drive_enable), .diag_mux(diag_mux)
);

/* dv/supply_fault_reaction_tb_top.sv */
// Testbench for supply_fault_reaction: fault rows, then hand tests.
// Assumes shortened filters (4 and 3) so each row settles in 12 cycles.
`timescale 1ns/1ps
module supply_fault_reaction_tb_top import fault_pkg::*;;
  localparam logic [15:0] CLEAN = 16'h92b2; // Every comparator quiet
  typedef struct {int b; logic [3:0] cfg; logic rn, dv; logic [1:0] st;
                  logic [7:0] s2; logic dg;} row_t;
  // Bit flipped, config, reset, drive, state (3 = skip), status, diag
  row_t rows [21] = '{
    '{15,0,0,0,2,8'h00,1}, '{14,0,0,0,2,8'h00,1}, '{13,0,0,0,2,8'h00,1},
    '{11,0,0,0,2,8'h00,1}, '{10,0,0,0,2,8'h00,1}, '{12,0,1,1,0,8'h00,1},
    '{9,0,1,1,0,8'h40,1}, '{8,0,1,1,0,8'h80,1}, '{7,0,1,1,0,8'h10,1},
    '{6,0,1,0,0,8'h20,1}, '{5,0,0,0,1,8'h04,1}, '{4,0,1,1,0,8'h00,0},
    '{4,2,0,0,1,8'h04,1}, '{5,2,1,1,0,8'h00,0}, '{3,0,1,0,0,8'h08,1},
    '{2,2,1,0,0,8'h08,1}, '{2,0,1,1,0,8'h00,0}, '{1,0,1,1,0,8'h01,1},
    '{1,1,0,0,1,8'h01,1}, '{0,0,1,1,0,8'h02,1}, '{0,1,1,0,0,8'h02,1}};
  logic        clk_sys, rst_b, pready, pslverr, er;
  logic        mcu_reset_out_n, safing_drive_enable, diag_mux, irq;
  comp_in_t    compIn;
  apb_req_t    apbReq;
  logic [31:0] prdata, rd;
  int          resetCount, resets, cycles, err_count, total_checks;

  supply_fault_reaction #(.SHORT_LEN(4), .LONG_LEN(3)) uut (
    .clk_sys(clk_sys), .rst_b(rst_b), .compIn(compIn), .apbReq(apbReq),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mcu_reset_out_n(mcu_reset_out_n), .diag_mux(diag_mux), .irq(irq),
    .safing_drive_enable(safing_drive_enable));
  mcu_model mcu (.clk_sys(clk_sys), .rst_b(rst_b), .resetCount(resetCount),
    .mcu_reset_out_n(mcu_reset_out_n));

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    apbReq <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    apbReq <= '0;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Diag position of the fault on comparator bit b
  function automatic logic [3:0] diagPos(input int b);
    return 4'((b >= 6) ? 17 - b : (b >= 4) ? 12 : (b >= 2) ? 13 : 15 - b);
  endfunction

  always #4 clk_sys = ~clk_sys;
  // Hang guard, well above the run of about 780 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  initial begin
    clk_sys = 1'b0;
    rst_b = 1'b0;
    compIn = comp_in_t'(CLEAN);
    apbReq = '0;
    waitc(20);
    rst_b <= 1'b1;
    apb(0, ADDR_CONFIG, 0);
    chk("config reset", CFG_RESET, rd);
    apb(0, 12'h0fc, 0);
    chk("unmapped err", 1, er);
    chk("unmapped data", 0, rd);
    chk("reset released", 1, mcu_reset_out_n);
    $display("register test done");
    foreach (rows[i]) begin
      apb(1, ADDR_CONFIG, {24'h0, diagPos(rows[i].b), rows[i].cfg});
      compIn <= comp_in_t'(CLEAN ^ (16'h1 << rows[i].b));
      waitc(12);
      chk("reset out", rows[i].rn, mcu_reset_out_n);
      chk("drive", rows[i].dv, safing_drive_enable);
      chk("diag", rows[i].dg, diag_mux);
      apb(0, ADDR_STATUS2, 0);
      chk("status two", rows[i].s2, rd[7:0]);
      apb(0, ADDR_STATE, 0);
      if (rows[i].st != 3) chk("state", rows[i].st, rd[1:0]);
      if (!rows[i].rn) resets++;
      compIn <= comp_in_t'(CLEAN);
      waitc(12);
      chk("recover", 2'b11, {mcu_reset_out_n, safing_drive_enable});
      $display("row %0d done", i);
    end
    chk("mcu resets", resets, resetCount);
    // Pulses shorter than the filter, split by a gap, never set a flag
    apb(1, ADDR_IRQ_STAT, 32'h3fff);
    repeat (2) begin
      compIn <= comp_in_t'(CLEAN ^ 16'h8000);
      waitc(3);
      compIn <= comp_in_t'(CLEAN);
      waitc(1);
    end
    waitc(8);
    chk("glitch", 1, mcu_reset_out_n);
    apb(0, ADDR_IRQ_STAT, 0);
    chk("glitch event", 0, rd);
    $display("glitch test done");
    // Interrupt masked, raised, sticky after the fault, then cleared
    apb(1, ADDR_IRQ_MASK, 0);
    compIn <= comp_in_t'(CLEAN ^ 16'h0080);
    waitc(12);
    chk("irq masked", 0, irq);
    apb(0, ADDR_LIVE, 0);
    chk("live flags", 32'h100, rd);
    apb(1, ADDR_IRQ_MASK, 32'h100);
    waitc(2);
    chk("irq raised", 1, irq);
    compIn <= comp_in_t'(CLEAN);
    waitc(12);
    chk("irq sticky", 1, irq);
    apb(1, ADDR_IRQ_STAT, 32'h100);
    waitc(2);
    chk("irq cleared", 0, irq);
    $display("interrupt test done");
    tally_and_finish();
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
endmodule
